// file: verilog/pch_defs.svh
// Register offsets, field positions, reset values and timing figures of the channel controller.
`ifndef PCH_DEFS_SVH
`define PCH_DEFS_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define PCH_OFS_CTRL      8'h00
`define PCH_OFS_DATA      8'h04
`define PCH_OFS_CFG46     8'h08
`define PCH_OFS_REG1      8'h0c
`define PCH_OFS_REG2      8'h10
`define PCH_OFS_REG3      8'h14
`define PCH_OFS_STATUS    8'h18
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PCH_CTRL_AND_BIT   0
`define PCH_CTRL_LATCH_BIT 1
`define PCH_RG_MODE_LSB    0
`define PCH_RG_OFF_LSB     2
`define PCH_RG_PKT_LSB     4
`define PCH_RG_PKC_LSB     10
`define PCH_RG_HDC_LSB     18
`define PCH_CFG_LS_LSB     0
`define PCH_CFG_OLD_LSB    3
`define PCH_CFG_BPD_LSB    6
`define PCH_ST_ON_LSB      0
`define PCH_ST_OT_LSB      6
`define PCH_ST_LOT_BIT     12
// ----------------------------------------------------------------------------
// Reset values and mode codes
// ----------------------------------------------------------------------------
`define PCH_RST_PEAK_CODE  8'h18
`define PCH_RST_HOLD_CODE  8'h0a
`define PCH_RST_OFF_SEL    2'h1
`define PCH_RST_MODE       2'h1
`define PCH_MODE_HOLD      2'h0
`define PCH_MODE_MINPK     2'h1
`define PCH_MODE_PROGPK    2'h2
`define PCH_PKT_MAX        6'h24
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PCH_CLK_PERIOD_NS  4
`define PCH_BLANK_NS       20000
`define PCH_STEP_NS        100000
`define PCH_BLANK_CYC      ((`PCH_BLANK_NS + `PCH_CLK_PERIOD_NS - 1) / `PCH_CLK_PERIOD_NS)
`define PCH_STEP_CYC       (`PCH_STEP_NS / `PCH_CLK_PERIOD_NS)
`endif

// file: verilog/pch_pkg.sv
// Types shared by the channel controller modules.
package pch_pkg;
  typedef logic [1:0] pch_mode_t;
  typedef logic [7:0] pch_thr_t;
  typedef logic [7:0] pch_addr_t;
  typedef logic [31:0] pch_word_t;
  typedef enum logic [2:0] {
    PCH_IDLE,
    PCH_ON_PEAK,
    PCH_OFF_PEAK,
    PCH_ON_HOLD,
    PCH_OFF_HOLD
  } pch_reg_state_t;
endpackage : pch_pkg

// file: verilog/pch_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module pch_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule : pch_sync

// file: verilog/pch_regulator.sv
// Peak-and-hold current regulator with fixed off-time and leading-edge blanking.
`timescale 1ns/1ps
`include "pch_defs.svh"
module pch_regulator #(
  parameter int BLANK_CYCLES = `PCH_BLANK_CYC,
  parameter int STEP_CYCLES  = `PCH_STEP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              enable_i,
  input  wire logic              reached_i,
  input  wire pch_pkg::pch_mode_t mode_i,
  input  wire logic [1:0]        off_sel_i,
  input  wire logic [5:0]        peak_code_i,
  output logic                   drive_o,
  output logic                   use_peak_o
);
  import pch_pkg::*;

  pch_reg_state_t state_reg;
  pch_reg_state_t state_next;
  logic [19:0]    blank_reg;
  logic [19:0]    off_reg;
  logic [19:0]    peak_reg;
  logic           trip;
  logic           off_done;
  logic           peak_over;
  logic           turn_on;

  function automatic logic [19:0] scale(input logic [5:0] n);
    scale = 20'(int'(n) * STEP_CYCLES);
  endfunction : scale

  // Threshold comparison is masked until blanking has run out.
  assign trip      = reached_i && (blank_reg == 20'h0) &&
                     (state_reg == PCH_ON_PEAK || state_reg == PCH_ON_HOLD);
  assign off_done  = (off_reg == 20'h0) &&
                     (state_reg == PCH_OFF_PEAK || state_reg == PCH_OFF_HOLD);
  assign peak_over = (mode_i == `PCH_MODE_PROGPK) && (peak_reg == 20'h0) &&
                     (state_reg == PCH_ON_PEAK || state_reg == PCH_OFF_PEAK);
  assign turn_on   = enable_i && (state_reg == PCH_IDLE || (off_done && !peak_over));

  always_comb begin
    state_next = state_reg;
    if (!enable_i) begin
      state_next = PCH_IDLE;
    end else begin
      unique case (state_reg)
        PCH_IDLE: begin
          if (mode_i == `PCH_MODE_MINPK || mode_i == `PCH_MODE_PROGPK) begin
            state_next = PCH_ON_PEAK;
          end else begin
            state_next = PCH_ON_HOLD;
          end
        end
        PCH_ON_PEAK: begin
          if (peak_over) begin
            state_next = PCH_ON_HOLD;
          end else if (trip && mode_i == `PCH_MODE_PROGPK) begin
            state_next = PCH_OFF_PEAK;
          end else if (trip) begin
            state_next = PCH_OFF_HOLD;
          end
        end
        PCH_OFF_PEAK: begin
          if (peak_over) begin
            state_next = PCH_OFF_HOLD;
          end else if (off_done) begin
            state_next = PCH_ON_PEAK;
          end
        end
        PCH_ON_HOLD: begin
          if (trip) begin
            state_next = PCH_OFF_HOLD;
          end
        end
        PCH_OFF_HOLD: begin
          if (off_done) begin
            state_next = PCH_ON_HOLD;
          end
        end
        default: state_next = PCH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg  <= PCH_IDLE;
      drive_o    <= 1'b0;
      use_peak_o <= 1'b0;
    end else begin
      state_reg  <= state_next;
      drive_o    <= (state_next == PCH_ON_PEAK || state_next == PCH_ON_HOLD);
      use_peak_o <= (state_next == PCH_ON_PEAK || state_next == PCH_OFF_PEAK);
    end
  end

  // Blanking restarts on every turn-on, internal or external.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blank_reg <= 20'h0;
    end else if (turn_on) begin
      blank_reg <= 20'(BLANK_CYCLES);
    end else if (blank_reg != 20'h0) begin
      blank_reg <= blank_reg - 20'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_reg <= 20'h0;
    end else if (trip) begin
      off_reg <= scale({4'h0, off_sel_i} + 6'h1) - 20'h1;
    end else if (off_reg != 20'h0) begin
      off_reg <= off_reg - 20'h1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      peak_reg <= 20'h0;
    end else if (state_reg == PCH_IDLE) begin
      peak_reg <= scale(peak_code_i);
    end else if (peak_reg != 20'h0) begin
      peak_reg <= peak_reg - 20'h1;
    end
  end
endmodule : pch_regulator

// file: verilog/pch_channel_ctrl.sv
// Six-channel output controller with overtemperature handling and current regulation on channels 1 to 3.
`timescale 1ns/1ps
`include "pch_defs.svh"

module pch_channel_ctrl #(
  parameter int BLANK_CYCLES = `PCH_BLANK_CYC,
  parameter int STEP_CYCLES  = `PCH_STEP_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire pch_pkg::pch_addr_t addr_i,
  input  wire pch_pkg::pch_word_t wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output pch_pkg::pch_word_t     rdata_o,
  input  wire logic [5:0]        in_pin_i,
  input  wire logic              global_output_disable_n_i,
  input  wire logic [5:0]        chan_overtemp_i,
  input  wire logic              logic_overtemp_i,
  input  wire logic [2:0]        current_reached_i,
  output logic [5:0]             out_on_o,
  output logic [23:0]            thr_code_o,
  output logic [2:0]             lowside_o,
  output logic [2:0]             open_load_det_dis_o,
  output logic [2:0]             bypass_det_dis_o,
  output logic                   logic_overtemp_o
);
  import pch_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  logic [5:0] in_s;
  logic       gdis_n_s;
  logic [5:0] cot_s;
  logic       lot_s;
  logic [2:0] reach_s;

  // Comparator outputs are treated as asynchronous pins like the rest.
  pch_sync #(
    .WIDTH (17)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({current_reached_i, logic_overtemp_i, chan_overtemp_i,
                 global_output_disable_n_i, in_pin_i}),
    .sync_o    ({reach_s, lot_s, cot_s, gdis_n_s, in_s})
  );

  // --------------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------------
  logic       and_mode_reg;
  logic       latch_mode_reg;
  logic [5:0] data_reg;
  logic [8:0] cfg46_reg;
  pch_mode_t  mode_reg      [3];
  logic [1:0] off_sel_reg   [3];
  logic [5:0] peak_time_reg [3];
  pch_thr_t   peak_thr_reg  [3];
  pch_thr_t   hold_thr_reg  [3];
  logic [5:0] ot_latch_reg;

  function automatic logic [5:0] clip_pkt(input logic [5:0] v);
    clip_pkt = (v > `PCH_PKT_MAX) ? `PCH_PKT_MAX : v;
  endfunction : clip_pkt

  function automatic pch_word_t pack_reg(input int i);
    pack_reg = '0;
    pack_reg[`PCH_RG_MODE_LSB +: 2] = mode_reg[i];
    pack_reg[`PCH_RG_OFF_LSB +: 2]  = off_sel_reg[i];
    pack_reg[`PCH_RG_PKT_LSB +: 6]  = peak_time_reg[i];
    pack_reg[`PCH_RG_PKC_LSB +: 8]  = peak_thr_reg[i];
    pack_reg[`PCH_RG_HDC_LSB +: 8]  = hold_thr_reg[i];
  endfunction : pack_reg

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      and_mode_reg   <= 1'b0;
      latch_mode_reg <= 1'b0;
      data_reg       <= 6'h0;
      cfg46_reg      <= 9'h0;
    end else if (wr_i) begin
      if (addr_i == `PCH_OFS_CTRL) begin
        and_mode_reg   <= wdata_i[`PCH_CTRL_AND_BIT];
        latch_mode_reg <= wdata_i[`PCH_CTRL_LATCH_BIT];
      end
      if (addr_i == `PCH_OFS_DATA) begin
        data_reg <= wdata_i[5:0];
      end
      if (addr_i == `PCH_OFS_CFG46) begin
        cfg46_reg <= wdata_i[8:0];
      end
    end
  end

  // Thresholds come out of reset at the 2.4A peak and 1A hold codes.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 3; i++) begin
        mode_reg[i]      <= `PCH_RST_MODE;
        off_sel_reg[i]   <= `PCH_RST_OFF_SEL;
        peak_time_reg[i] <= 6'h0;
        peak_thr_reg[i]  <= `PCH_RST_PEAK_CODE;
        hold_thr_reg[i]  <= `PCH_RST_HOLD_CODE;
      end
    end else if (wr_i) begin
      for (int i = 0; i < 3; i++) begin
        if (addr_i == 8'(`PCH_OFS_REG1 + 4 * i)) begin
          mode_reg[i]      <= wdata_i[`PCH_RG_MODE_LSB +: 2];
          off_sel_reg[i]   <= wdata_i[`PCH_RG_OFF_LSB +: 2];
          peak_time_reg[i] <= clip_pkt(wdata_i[`PCH_RG_PKT_LSB +: 6]);
          peak_thr_reg[i]  <= wdata_i[`PCH_RG_PKC_LSB +: 8];
          hold_thr_reg[i]  <= wdata_i[`PCH_RG_HDC_LSB +: 8];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Request combination and protection
  // --------------------------------------------------------------------------
  logic [5:0] req;
  logic [5:0] req_prev_reg;
  logic [5:0] req_rise;
  logic [5:0] ot_hit;
  logic [5:0] enable;
  logic [2:0] reg_drive;
  logic [2:0] reg_peak;
  logic [5:0] out_next;

  // Both sources are active high.
  assign req = and_mode_reg ? (in_s & data_reg) : (in_s | data_reg);
  assign req_rise = req & ~req_prev_reg;
  // The sensor only counts while the switch is actually conducting.
  assign ot_hit = cot_s & out_on_o;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_prev_reg <= 6'h0;
    end else begin
      req_prev_reg <= req;
    end
  end

  // A shutdown arriving together with a clear condition keeps the latch set.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_latch_reg <= 6'h0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (ot_hit[i]) begin
          ot_latch_reg[i] <= 1'b1;
        end else if (latch_mode_reg && req_rise[i]) begin
          ot_latch_reg[i] <= 1'b0;
        end else if (!latch_mode_reg && !cot_s[i]) begin
          ot_latch_reg[i] <= 1'b0;
        end
      end
    end
  end

  // The overtemperature hit cuts the channel in the same cycle the latch is being set.
  assign enable = req & {6{gdis_n_s}} & ~ot_latch_reg & ~ot_hit;

  // --------------------------------------------------------------------------
  // Current regulators for channels 1 to 3
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_reg
    pch_regulator #(
      .BLANK_CYCLES (BLANK_CYCLES),
      .STEP_CYCLES  (STEP_CYCLES)
    ) u_reg (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .enable_i    (enable[g]),
      .reached_i   (reach_s[g]),
      .mode_i      (mode_reg[g]),
      .off_sel_i   (off_sel_reg[g]),
      .peak_code_i (peak_time_reg[g]),
      .drive_o     (reg_drive[g]),
      .use_peak_o  (reg_peak[g])
    );
  end

  assign out_next = {enable[5:3], enable[2:0] & reg_drive};

  // --------------------------------------------------------------------------
  // Output latches and analog-side settings
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_on_o <= 6'h0;
    end else begin
      out_on_o <= out_next;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      thr_code_o <= {3{`PCH_RST_HOLD_CODE}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        thr_code_o[8*i +: 8] <= reg_peak[i] ? peak_thr_reg[i] : hold_thr_reg[i];
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lowside_o           <= 3'h0;
      open_load_det_dis_o <= 3'h0;
      bypass_det_dis_o    <= 3'h0;
    end else begin
      lowside_o           <= cfg46_reg[`PCH_CFG_LS_LSB +: 3];
      open_load_det_dis_o <= cfg46_reg[`PCH_CFG_OLD_LSB +: 3];
      bypass_det_dis_o    <= cfg46_reg[`PCH_CFG_BPD_LSB +: 3];
    end
  end

  // The logic-area sensor is watched regardless of channel state.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      logic_overtemp_o <= 1'b0;
    end else begin
      logic_overtemp_o <= lot_s;
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  pch_word_t rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (addr_i)
      `PCH_OFS_CTRL: begin
        rd_mux[`PCH_CTRL_AND_BIT]   = and_mode_reg;
        rd_mux[`PCH_CTRL_LATCH_BIT] = latch_mode_reg;
      end
      `PCH_OFS_DATA:  rd_mux[5:0] = data_reg;
      `PCH_OFS_CFG46: rd_mux[8:0] = cfg46_reg;
      `PCH_OFS_REG1:  rd_mux = pack_reg(0);
      `PCH_OFS_REG2:  rd_mux = pack_reg(1);
      `PCH_OFS_REG3:  rd_mux = pack_reg(2);
      `PCH_OFS_STATUS: begin
        rd_mux[`PCH_ST_ON_LSB +: 6] = out_on_o;
        rd_mux[`PCH_ST_OT_LSB +: 6] = ot_latch_reg;
        rd_mux[`PCH_ST_LOT_BIT]     = logic_overtemp_o;
      end
      default: rd_mux = '0;
    endcase
  end

  // Read data stand for one cycle per cycle that rd_i is high; an unmapped address reads zero.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : pch_channel_ctrl

// file: bench/pch_load_model.sv
// Inductive load with current comparator behind channels 1 to 3.
`timescale 1ns/1ps
module pch_load_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  drive_i,
  input  wire logic [23:0] thr_i,
  input  wire logic        short_i,
  output logic      [2:0]  reached_o
);
  int unsigned cur [3];

  // A shorted load trips the comparator at once, so blanking alone keeps the switch on.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (drive_i[i]) cur[i] <= cur[i] + 1;
      else if (cur[i] > 0) cur[i] <= cur[i] - 1;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      reached_o[i] = short_i || (cur[i] >= 32'(thr_i[8*i +: 8]));
    end
  end
endmodule : pch_load_model

// file: bench/pch_channel_ctrl_checker.sv
// Port-level assertions of the channel controller.
`timescale 1ns/1ps
module pch_channel_ctrl_checker #(
  parameter int BLANK_CYCLES = 8,
  parameter int STEP_CYCLES  = 20
) (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [5:0]  in_pin_i,
  input wire logic        global_output_disable_n_i,
  input wire logic [5:0]  chan_overtemp_i,
  input wire logic        logic_overtemp_i,
  input wire logic [5:0]  out_on_o,
  input wire logic [23:0] thr_code_o,
  input wire logic [2:0]  lowside_o,
  input wire logic        logic_overtemp_o
);
  logic [3:0][5:0] ot_hist;
  logic [5:0]      ot_all;
  logic [3:0]      calm_cnt;
  logic            calm;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Channel 1 counts as calm once its request has been steady long enough to reach the output.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ot_hist  <= '0;
      calm_cnt <= 4'h0;
    end else begin
      ot_hist <= {ot_hist[2:0], chan_overtemp_i};
      if (!(global_output_disable_n_i && in_pin_i[0] && !chan_overtemp_i[0])) calm_cnt <= 4'h0;
      else if (calm_cnt != 4'hf) calm_cnt <= calm_cnt + 4'h1;
    end
  end
  assign ot_all = chan_overtemp_i & ot_hist[0] & ot_hist[1] & ot_hist[2] & ot_hist[3];
  assign calm   = calm_cnt >= 4'h6;

  property p_rst;
    !$past(reset_n_i) |-> out_on_o == 6'h0 && thr_code_o == 24'h0a0a0a && lowside_o == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared by reset");
  property p_dis;
    (!global_output_disable_n_i)[*4] |-> out_on_o == 6'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("output on while disabled");
  property p_en;
    |(out_on_o & ~$past(out_on_o)) |-> $past(global_output_disable_n_i, 2)
      || $past(global_output_disable_n_i, 3) || $past(global_output_disable_n_i, 4);
  endproperty
  a_en: assert property (p_en) else $error("output turned on without enable");
  property p_ot;
    (ot_all & out_on_o & $past(out_on_o)) == 6'h0;
  endproperty
  a_ot: assert property (p_ot) else $error("hot channel kept on");
  property p_lot_hi;
    logic_overtemp_i[*4] |-> logic_overtemp_o;
  endproperty
  a_lot_hi: assert property (p_lot_hi) else $error("logic fault flag missing");
  property p_lot_lo;
    (!logic_overtemp_i)[*4] |-> !logic_overtemp_o;
  endproperty
  a_lot_lo: assert property (p_lot_lo) else $error("logic fault flag stuck");
  property p_blank;
    $rose(out_on_o[0]) && calm |-> (out_on_o[0] || !calm)[*8];
  endproperty
  a_blank: assert property (p_blank) else $error("switch off inside blanking");
  property p_off;
    $fell(out_on_o[0]) && calm |=> (!out_on_o[0] || !calm)[*8];
  endproperty
  a_off: assert property (p_off) else $error("off-time too short");
endmodule : pch_channel_ctrl_checker

// file: bench/pch_channel_ctrl_test.sv
// Self-checking test of the channel controller.
`timescale 1ns/1ps
`include "pch_defs.svh"
module pch_channel_ctrl_test;
  import pch_pkg::*;
  logic        clk_i;
  logic        reset_n_i;
  pch_addr_t   addr_i;
  pch_word_t   wdata_i;
  logic        wr_i;
  logic        rd_i;
  pch_word_t   rdata_o;
  logic [5:0]  in_pin_i;
  logic        global_output_disable_n_i;
  logic [5:0]  chan_overtemp_i;
  logic        logic_overtemp_i;
  logic [2:0]  current_reached_i;
  logic [5:0]  out_on_o;
  logic [23:0] thr_code_o;
  logic [2:0]  lowside_o;
  logic [2:0]  open_load_det_dis_o;
  logic [2:0]  bypass_det_dis_o;
  logic        logic_overtemp_o;
  logic        short_load;
  int          fail_count = 0;
  int          comparisons = 0;

  pch_channel_ctrl #(.BLANK_CYCLES(8), .STEP_CYCLES(20)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .in_pin_i(in_pin_i),
    .global_output_disable_n_i(global_output_disable_n_i), .chan_overtemp_i(chan_overtemp_i),
    .logic_overtemp_i(logic_overtemp_i), .current_reached_i(current_reached_i),
    .out_on_o(out_on_o), .thr_code_o(thr_code_o), .lowside_o(lowside_o),
    .open_load_det_dis_o(open_load_det_dis_o), .bypass_det_dis_o(bypass_det_dis_o),
    .logic_overtemp_o(logic_overtemp_o));
  pch_load_model i_load (.clk_i(clk_i), .drive_i(out_on_o[2:0]), .thr_i(thr_code_o),
    .short_i(short_load), .reached_o(current_reached_i));

  // --------------------------------------------------------------------------
  // Access tasks; each starts and ends just after a rising edge
  // --------------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wr(input pch_addr_t a, input pch_word_t d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    // One idle edge keeps the next call from raising the strobe in the step that lowers it.
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input pch_addr_t a, input pch_word_t e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    // Read data are settled mid-cycle, away from the edge that launches them.
    @(negedge clk_i);
    chk("rdata", rdata_o, e);
    @(posedge clk_i);
  endtask : rd
  task automatic wait_on(input logic v);
    int n;
    n = 0;
    while (out_on_o[0] !== v && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    chk("wait", 32'(n < 500), 32'h1);
  endtask : wait_on
  task automatic results();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    results();
  end

  initial begin
    reset_n_i = 1'b0;
    addr_i = 8'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    in_pin_i = 6'h0;
    global_output_disable_n_i = 1'b1;
    chan_overtemp_i = 6'h0;
    logic_overtemp_i = 1'b0;
    short_load = 1'b0;
    cyc(3);
    reset_n_i <= 1'b1;
    cyc(3);
    chk("thr", thr_code_o, {3{`PCH_RST_HOLD_CODE}});
    for (int c = 0; c < 3; c++) rd(8'(`PCH_OFS_REG1 + 4 * c), {6'h0, `PCH_RST_HOLD_CODE,
      `PCH_RST_PEAK_CODE, 6'h0, `PCH_RST_OFF_SEL, `PCH_RST_MODE});
    rd(8'h1c, 32'h0);
    for (int m = 0; m < 8; m++) begin
      wr(`PCH_OFS_CTRL, 32'(m[2]));
      wr(`PCH_OFS_DATA, 32'(m[1]) << 3);
      in_pin_i[3] <= m[0];
      cyc(6);
      chk("out4", out_on_o[3], m[2] ? m[1] & m[0] : m[1] | m[0]);
    end
    wr(`PCH_OFS_CFG46, 32'h1a5);
    cyc(2);
    chk("cfg", {bypass_det_dis_o, open_load_det_dis_o, lowside_o}, 9'h1a5);
    wr(`PCH_OFS_CTRL, 32'h0);
    wr(`PCH_OFS_DATA, 32'h0);
    in_pin_i <= 6'h18;
    global_output_disable_n_i <= 1'b0;
    cyc(8);
    chk("dis", out_on_o, 6'h0);
    global_output_disable_n_i <= 1'b1;
    cyc(6);
    chk("en", out_on_o, 6'h18);
    chan_overtemp_i <= 6'h08;
    cyc(6);
    chk("ot", out_on_o, 6'h10);
    chan_overtemp_i <= 6'h0;
    cyc(6);
    chk("restart", out_on_o, 6'h18);
    wr(`PCH_OFS_CTRL, 32'h2);
    chan_overtemp_i <= 6'h08;
    cyc(6);
    chan_overtemp_i <= 6'h0;
    cyc(10);
    chk("latch", out_on_o, 6'h10);
    in_pin_i[3] <= 1'b0;
    cyc(6);
    in_pin_i[3] <= 1'b1;
    cyc(6);
    chk("relatch", out_on_o, 6'h18);
    in_pin_i[3] <= 1'b0;
    cyc(6);
    chan_overtemp_i <= 6'h08;
    cyc(6);
    rd(`PCH_OFS_STATUS, 32'h10);
    chan_overtemp_i <= 6'h0;
    in_pin_i <= 6'h0;
    logic_overtemp_i <= 1'b1;
    cyc(6);
    rd(`PCH_OFS_STATUS, 32'h1000);
    logic_overtemp_i <= 1'b0;
    cyc(6);
    chk("lot", logic_overtemp_o, 1'b0);
    wr(`PCH_OFS_CTRL, 32'h0);
    for (int m = 0; m < 3; m++) begin
      wr(`PCH_OFS_REG1, {6'h0, 8'h08, 8'h14, 6'h2, 2'h0, 2'(m)});
      in_pin_i[0] <= 1'b1;
      wait_on(1'b1);
      cyc(2);
      chk("thr_first", thr_code_o[7:0], m == 0 ? 8'h08 : 8'h14);
      cyc(400);
      chk("thr_hold", thr_code_o[7:0], 8'h08);
      in_pin_i[0] <= 1'b0;
      cyc(6);
      chk("abort", out_on_o[0], 1'b0);
    end
    short_load <= 1'b1;
    in_pin_i[0] <= 1'b1;
    wait_on(1'b1);
    cyc(5);
    chk("blank", out_on_o[0], 1'b1);
    wait_on(1'b0);
    wait_on(1'b1);
    wait_on(1'b0);
    in_pin_i[0] <= 1'b0;
    short_load <= 1'b0;
    cyc(10);
    results();
  end
endmodule : pch_channel_ctrl_test

bind pch_channel_ctrl pch_channel_ctrl_checker #(.BLANK_CYCLES(BLANK_CYCLES),
  .STEP_CYCLES(STEP_CYCLES)) i_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .in_pin_i(in_pin_i), .global_output_disable_n_i(global_output_disable_n_i),
  .chan_overtemp_i(chan_overtemp_i), .logic_overtemp_i(logic_overtemp_i),
  .out_on_o(out_on_o), .thr_code_o(thr_code_o), .lowside_o(lowside_o),
  .logic_overtemp_o(logic_overtemp_o));
